/* File: hw/uart_host_pkg.sv */
// Constants and types for one UART channel's host-side pin port
// Summary of operation
// RULE_01: Data bit 0 of the host bus is the least significant bit and the first bit on the serial line.
// RULE_02: A low set-ready input means the modem is powered and ready; it never affects transmit or receive.
// RULE_03: Writing 1 to modem control bit 0 drives the active-low terminal-ready output low.
// RULE_04: Writing 0 to modem control bit 0, or reset, drives terminal-ready high; it never affects data flow.
// RULE_05: The interrupt output is high only when gating allows it, the source is enabled and a condition is present.
// RULE_06: Interrupt conditions are receiver error, received data available, transmit empty and modem status change.
// RULE_07: There is one interrupt output per channel, live only in the separate-strobe bus mode.
// RULE_08: With the interrupt-select input high the interrupt output is always driven, overriding control bit 3.
// RULE_09: With interrupt-select low the interrupt output is driven only while control bit 3 is 1, else high impedance.
// RULE_10: A falling read strobe puts the register chosen by the three address lines onto the data bus.
// RULE_11: In the multiplexed-bus mode the read strobe and interrupt-select pins are ignored.
// RULE_12: A falling write strobe copies the data bus into the register chosen by the three address lines.
// RULE_13: The host selects the channel by holding its active-low channel select low.
// RULE_14: The host holds select and address steady while a strobe is low and releases the bus while reading.
package uart_host_pkg;

    // ------------------------------------------------------------
    // Widths and register offsets
    // ------------------------------------------------------------
    localparam int         DATA_W      = 8;
    localparam int         ADDR_W      = 3;
    localparam logic [2:0] ADDR_DATA   = 3'h0;
    localparam logic [2:0] ADDR_IER    = 3'h1;
    localparam logic [2:0] ADDR_ISR    = 3'h2;
    localparam logic [2:0] ADDR_MCR    = 3'h4;
    localparam logic [2:0] ADDR_MSR    = 3'h6;
    localparam logic [2:0] ADDR_SCR    = 3'h7;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int NUM_EVT          = 4;
    localparam int EVT_RX_ERR       = 0;
    localparam int EVT_RX_AVAIL     = 1;
    localparam int EVT_TX_EMPTY     = 2;
    localparam int EVT_MODEM        = 3;
    localparam int MCR_TERM_READY   = 0;
    localparam int MCR_IRQ_GATE     = 3;
    localparam int MSR_SET_READY    = 0;
    localparam int MSR_SET_DELTA    = 1;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] IER_RESET = 8'h00;
    localparam logic [7:0] MCR_RESET = 8'h00;
    localparam logic [7:0] SCR_RESET = 8'h00;
    localparam logic [3:0] ISR_RESET = 4'h0;

    typedef enum logic {MODE_STROBE, MODE_MUX} bus_mode_t;

endpackage

/* File: hw/strobe_edge.sv */
// Falling-edge detector for an active-low host strobe
`timescale 1ns/1ps
module strobe_edge (
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic ce,
    input  wire logic level_n,
    output logic      fall
);
    typedef struct packed {
        logic prev;
    } edge_state_t;

    edge_state_t s_reg;
    edge_state_t s_next;

    always_comb begin
        s_next      = s_reg;
        s_next.prev = level_n;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_reg <= '{prev: 1'b1};
        end else if (ce) begin
            s_reg <= s_next;
        end
    end

    // Held high at reset so a strobe already low at release counts as an edge
    assign fall = s_reg.prev & ~level_n;

endmodule

/* File: hw/uart_host_port.sv */
// Host pin port of one UART channel: strobed bus, interrupt pin, modem lines
//
// Our own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module uart_host_port
    import uart_host_pkg::*;
#(
    parameter int BUS_W = uart_host_pkg::DATA_W
) (
    input  wire logic                      clk,
    input  wire logic                      arst_n,
    input  wire logic                      ce,
    input  wire uart_host_pkg::bus_mode_t  bus_mode,
    input  wire logic                      channel_select_n,
    input  wire logic [2:0]                register_address,
    input  wire logic                      write_strobe_n,
    input  wire logic                      read_strobe_n,
    input  wire logic [7:0]                host_data_in,
    output logic      [7:0]                host_data_out,
    output logic                           host_data_oe_n,
    input  wire logic                      irq_output_select,
    output logic                           channel_irq_out,
    output logic                           channel_irq_oe_n,
    input  wire logic                      set_ready_in,
    output logic                           terminal_ready_out,
    input  wire logic                      rx_error_evt,
    input  wire logic                      rx_avail_evt,
    input  wire logic                      tx_empty_evt,
    input  wire logic                      modem_change_evt,
    input  wire logic [7:0]                rx_data,
    output logic      [7:0]                tx_data,
    output logic                           tx_load,
    output logic                           rx_taken
);
    import uart_host_pkg::*;

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    if (BUS_W != DATA_W) begin : g_bad_width
        $error("uart_host_port serves an 8-bit host bus only");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0]         irq_enable_reg;
        logic [7:0]         modem_control_reg;
        logic [7:0]         scr;
        logic [NUM_EVT-1:0] isr;
        logic               sr_delta;
        logic               sr_prev;
        logic [7:0]         dout;
        logic               dout_oe_n;
        logic               irq;
        logic               irq_oe_n;
        logic               dtr_n;
        logic [7:0]         txd;
        logic               tx_load;
        logic               rx_taken;
    } state_t;

    localparam state_t STATE_RESET = '{
        irq_enable_reg: IER_RESET, modem_control_reg: MCR_RESET, scr: SCR_RESET, isr: ISR_RESET,
        sr_delta: 1'b0, sr_prev: 1'b0, dout: 8'h00, dout_oe_n: 1'b1,
        irq: 1'b0, irq_oe_n: 1'b1, dtr_n: 1'b1, txd: 8'h00,
        tx_load: 1'b0, rx_taken: 1'b0};

    state_t s_reg;
    state_t s_next;

    logic wr_fall;
    logic rd_fall;

    strobe_edge u_wr_edge (
        .clk     (clk),
        .arst_n  (arst_n),
        .ce      (ce),
        .level_n (write_strobe_n),
        .fall    (wr_fall)
    );

    strobe_edge u_rd_edge (
        .clk     (clk),
        .arst_n  (arst_n),
        .ce      (ce),
        .level_n (read_strobe_n),
        .fall    (rd_fall)
    );

    // ------------------------------------------------------------
    // Read multiplexer
    // ------------------------------------------------------------
    function automatic logic [7:0] read_value(input logic [2:0] a, input state_t s,
                                              input logic [7:0] rxd);
        logic [7:0] v;
        v = 8'h00;
        if (a == ADDR_DATA) begin
            v = rxd;
        end else if (a == ADDR_IER) begin
            v = s.irq_enable_reg;
        end else if (a == ADDR_ISR) begin
            v = {4'h0, s.isr};
        end else if (a == ADDR_MCR) begin
            v = s.modem_control_reg;
        end else if (a == ADDR_MSR) begin
            v = {6'h00, s.sr_delta, s.sr_prev};
        end else if (a == ADDR_SCR) begin
            v = s.scr;
        end
        return v;
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    logic               mode_strobe;
    logic               active;
    logic               wr_hit;
    logic               rd_hit;
    logic               sr_level;
    logic               sr_change;
    logic               gate;
    logic [NUM_EVT-1:0] evt;

    always_comb begin
        s_next           = s_reg;
        s_next.tx_load   = 1'b0;
        s_next.rx_taken  = 1'b0;
        mode_strobe      = (bus_mode == MODE_STROBE);
        // Other bus mode turns these pins to alternate use, so ignore them
        active           = mode_strobe & ~channel_select_n; // RULE_11 RULE_13
        wr_hit           = active & wr_fall;
        rd_hit           = active & rd_fall;
        // Low input means modem ready; only reported, never gates data
        sr_level         = ~set_ready_in; // RULE_02
        sr_change        = sr_level ^ s_reg.sr_prev;
        s_next.sr_prev   = sr_level;

        if (wr_hit) begin // RULE_12
            if (register_address == ADDR_DATA) begin
                // Bus bit 0 stays bit 0, the first bit shifted out
                s_next.txd     = host_data_in; // RULE_01
                s_next.tx_load = 1'b1;
            end else if (register_address == ADDR_IER) begin
                s_next.irq_enable_reg = host_data_in;
            end else if (register_address == ADDR_MCR) begin
                s_next.modem_control_reg = host_data_in;
            end else if (register_address == ADDR_SCR) begin
                s_next.scr = host_data_in;
            end
        end

        if (rd_hit) begin // RULE_10
            s_next.dout = read_value(register_address, s_reg, rx_data);
            if (register_address == ADDR_ISR) begin
                s_next.isr = ISR_RESET;
            end else if (register_address == ADDR_MSR) begin
                s_next.sr_delta = 1'b0;
            end else if (register_address == ADDR_DATA) begin
                s_next.rx_taken = 1'b1;
            end
        end

        // Sets after clears: an event in the clearing cycle survives
        evt                 = '0;
        evt[EVT_RX_ERR]     = rx_error_evt; // RULE_06
        evt[EVT_RX_AVAIL]   = rx_avail_evt;
        evt[EVT_TX_EMPTY]   = tx_empty_evt;
        evt[EVT_MODEM]      = modem_change_evt | sr_change;
        s_next.isr          = s_next.isr | evt;
        s_next.sr_delta     = s_next.sr_delta | sr_change;

        // Bus is driven only while the selected read strobe stays low
        s_next.dout_oe_n = ~(active & ~read_strobe_n);
        s_next.dtr_n     = ~s_next.modem_control_reg[MCR_TERM_READY]; // RULE_03 RULE_04

        gate = mode_strobe & (irq_output_select | s_next.modem_control_reg[MCR_IRQ_GATE]); // RULE_08 RULE_09
        s_next.irq_oe_n = ~gate; // RULE_07
        s_next.irq      = gate & (|(s_next.isr & s_next.irq_enable_reg[NUM_EVT-1:0])); // RULE_05
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_reg <= STATE_RESET;
        end else if (ce) begin
            s_reg <= s_next;
        end
    end

    assign host_data_out      = s_reg.dout;
    assign host_data_oe_n     = s_reg.dout_oe_n;
    assign channel_irq_out    = s_reg.irq;
    assign channel_irq_oe_n   = s_reg.irq_oe_n;
    assign terminal_ready_out = s_reg.dtr_n;
    assign tx_data            = s_reg.txd;
    assign tx_load            = s_reg.tx_load;
    assign rx_taken           = s_reg.rx_taken;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    dtr_set_a: // RULE_03
    assert property (@(posedge clk) disable iff (!arst_n)
        (ce && wr_hit && register_address == ADDR_MCR && host_data_in[0])
        |=> !terminal_ready_out)
    else $error("terminal ready not low after control bit 0 set");

    dtr_clear_a: // RULE_04
    assert property (@(posedge clk) disable iff (!arst_n)
        (ce && wr_hit && register_address == ADDR_MCR && !host_data_in[0])
        |=> terminal_ready_out)
    else $error("terminal ready not high after control bit 0 cleared");

    irq_cause_a: // RULE_05
    assert property (@(posedge clk) disable iff (!arst_n)
        channel_irq_out |-> (!channel_irq_oe_n && |(s_reg.isr & s_reg.irq_enable_reg[NUM_EVT-1:0])))
    else $error("interrupt high without an enabled pending condition");

    irq_forced_a: // RULE_08
    assert property (@(posedge clk) disable iff (!arst_n)
        (ce && mode_strobe && irq_output_select) |=> !channel_irq_oe_n)
    else $error("interrupt pin not driven with select high");

    irq_hiz_a: // RULE_09
    assert property (@(posedge clk) disable iff (!arst_n)
        (ce && mode_strobe && !irq_output_select && !s_next.modem_control_reg[MCR_IRQ_GATE])
        |=> (channel_irq_oe_n && !channel_irq_out))
    else $error("interrupt pin driven while gated off");

    read_data_a: // RULE_10
    assert property (@(posedge clk) disable iff (!arst_n)
        (ce && rd_hit && register_address == ADDR_IER)
        |=> (host_data_out == $past(s_reg.irq_enable_reg)) && !host_data_oe_n)
    else $error("read did not present the enable register");

    mux_mode_a: // RULE_11
    assert property (@(posedge clk) disable iff (!arst_n)
        (ce && bus_mode == MODE_MUX) |=> (host_data_oe_n && channel_irq_oe_n))
    else $error("pins driven in multiplexed mode");

    evt_sticky_a: // RULE_06
    assert property (@(posedge clk) disable iff (!arst_n)
        (ce && rx_error_evt) |=> s_reg.isr[EVT_RX_ERR] ##1 (s_reg.isr[EVT_RX_ERR] || $past(rd_hit)))
    else $error("receiver error condition lost");

    write_reg_a: // RULE_12
    assert property (@(posedge clk) disable iff (!arst_n)
        (ce && wr_hit && register_address == ADDR_SCR) |=> s_reg.scr == $past(host_data_in))
    else $error("write did not reach the scratch register");

endmodule

/* File: testbench/host_cpu.sv */
// Host processor model driving the strobed parallel bus of one channel
`timescale 1ns/1ps
module host_cpu (
    input  wire logic       clk,
    input  wire logic [7:0] host_data_out,
    input  wire logic       host_data_oe_n,
    output logic            channel_select_n,
    output logic [2:0]      register_address,
    output logic            write_strobe_n,
    output logic            read_strobe_n,
    output logic [7:0]      host_data_in
);
    logic       drv;
    logic [7:0] hval;
    logic [7:0] last;

    initial begin
        channel_select_n = 1'b1;
        register_address = 3'h0;
        write_strobe_n = 1'b1;
        read_strobe_n = 1'b1;
        drv = 1'b0;
        hval = 8'h00;
        last = 8'h00;
    end

    // Undriven bus wanders so a stale value never reads as valid
    assign host_data_in = !host_data_oe_n ? host_data_out : (drv ? hval : ~last);

    always @(posedge clk) begin
        last <= host_data_in;
    end

    task automatic wr(input logic [2:0] a, input logic [7:0] dv, input logic sel_n = 1'b0);
        @(posedge clk);
        channel_select_n <= sel_n;
        register_address <= a;
        hval <= dv;
        drv <= 1'b1;
        write_strobe_n <= 1'b0;
        @(posedge clk);
        write_strobe_n <= 1'b1;
        channel_select_n <= 1'b1;
        drv <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a, output logic [7:0] dv, output logic oe);
        @(posedge clk);
        channel_select_n <= 1'b0;
        register_address <= a;
        read_strobe_n <= 1'b0;
        @(posedge clk);
        read_strobe_n <= 1'b1;
        channel_select_n <= 1'b1;
        @(negedge clk);
        dv = host_data_in;
        oe = host_data_oe_n;
    endtask
endmodule

/* File: testbench/test_uart_host_pins_irq_modem.sv */
// Self-checking bench for the host pin port of one channel
`timescale 1ns/1ps
module test_uart_host_pins_irq_modem;
    import uart_host_pkg::*;
    logic        clk = 1'b0;
    logic        arst_n = 1'b0;
    logic        ce = 1'b1;
    bus_mode_t   bus_mode = MODE_STROBE;
    logic        irq_output_select = 1'b0;
    logic        set_ready_in = 1'b1;
    logic [3:0]  evt = 4'h0;
    logic [7:0]  rx_data = 8'h00;
    logic        channel_select_n, write_strobe_n, read_strobe_n, host_data_oe_n;
    logic        channel_irq_out, channel_irq_oe_n, terminal_ready_out, tx_load, rx_taken;
    logic [2:0]  register_address;
    logic [7:0]  host_data_in, host_data_out, tx_data, d, v;
    logic [7:0]  irq_enable_reg = 8'h00, modem_control_reg = 8'h00, isr = 8'h00;
    logic        oe;
    logic [31:0] seed = 32'h52;
    int          fail_count = 0;
    int          n_checks = 0;

    always #50 clk = ~clk;

    uart_host_port dut (.clk, .arst_n, .ce, .bus_mode, .channel_select_n, .register_address,
        .write_strobe_n, .read_strobe_n, .host_data_in, .host_data_out, .host_data_oe_n,
        .irq_output_select, .channel_irq_out, .channel_irq_oe_n, .set_ready_in,
        .terminal_ready_out, .rx_error_evt(evt[0]), .rx_avail_evt(evt[1]),
        .tx_empty_evt(evt[2]), .modem_change_evt(evt[3]), .rx_data, .tx_data, .tx_load,
        .rx_taken);
    host_cpu cpu (.clk, .host_data_out, .host_data_oe_n, .channel_select_n,
        .register_address, .write_strobe_n, .read_strobe_n, .host_data_in);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic chk_irq();
        logic g;
        g = irq_output_select | modem_control_reg[MCR_IRQ_GATE];
        chk(channel_irq_oe_n, !g);
        chk(channel_irq_out, g && ((isr & irq_enable_reg) != 8'h00));
    endtask

    task automatic conclude();
        $display("checks=%0d errors=%0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        repeat (3000) @(posedge clk);
        fail_count++;
        conclude();
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        @(negedge clk);
        chk(terminal_ready_out, 1'b1);
        chk(host_data_oe_n, 1'b1);
        chk_irq();
        repeat (4) begin
            v = rnd();
            cpu.wr(ADDR_SCR, v);
            rx_data <= ~v;
            cpu.wr(ADDR_IER, v);
            cpu.rd(ADDR_SCR, d, oe);
            chk(d, v);
            chk(oe, 1'b0);
            cpu.rd(ADDR_DATA, d, oe);
            chk(d, ~v);
            chk(rx_taken, 1'b1);
            cpu.rd(ADDR_IER, d, oe);
            chk(d, v);
            cpu.wr(3'h5, v);
            cpu.rd(3'h5, d, oe);
            chk(d, 8'h00);
            cpu.wr(ADDR_SCR, ~v, 1'b1);
            cpu.rd(ADDR_SCR, d, oe);
            chk(d, v);
            cpu.wr(ADDR_DATA, v);
            @(negedge clk);
            chk(tx_load, 1'b1);
            chk(tx_data, v);
        end
        cpu.wr(ADDR_MCR, 8'h01);
        @(negedge clk);
        chk(terminal_ready_out, 1'b0);
        cpu.wr(ADDR_MCR, 8'h00);
        @(negedge clk);
        chk(terminal_ready_out, 1'b1);
        for (int e = 0; e < NUM_EVT; e++) begin
            for (int g = 0; g < 5; g++) begin
                modem_control_reg = {4'h0, g[0] | g[2], 3'h1};
                irq_enable_reg = (g == 4) ? (~(8'h01 << e) & 8'h0F) : (8'h01 << e);
                cpu.wr(ADDR_MCR, modem_control_reg);
                irq_output_select <= g[1];
                cpu.wr(ADDR_IER, irq_enable_reg);
                evt[e] <= 1'b1;
                @(posedge clk);
                evt[e] <= 1'b0;
                isr = 8'h01 << e;
                @(negedge clk);
                chk_irq();
                chk(terminal_ready_out, 1'b0);
                cpu.rd(ADDR_ISR, d, oe);
                chk(d, isr);
                isr = 8'h00;
                @(negedge clk);
                chk_irq();
            end
        end
        @(posedge clk);
        set_ready_in <= 1'b0;
        cpu.rd(ADDR_MSR, d, oe);
        chk(d, 8'h03);
        cpu.rd(ADDR_ISR, d, oe);
        chk(d, 8'h08);
        chk(terminal_ready_out, 1'b0);
        @(posedge clk);
        bus_mode <= MODE_MUX;
        irq_output_select <= 1'b1;
        cpu.wr(ADDR_MCR, 8'h00);
        cpu.rd(ADDR_MCR, d, oe);
        chk(oe, 1'b1);
        chk(channel_irq_oe_n, 1'b1);
        chk(terminal_ready_out, 1'b0);
        @(posedge clk);
        bus_mode <= MODE_STROBE;
        cpu.rd(ADDR_MCR, d, oe);
        chk(d, modem_control_reg);
        // Frozen clock enable must swallow a whole write strobe
        ce <= 1'b0;
        cpu.wr(ADDR_SCR, ~v);
        ce <= 1'b1;
        cpu.rd(ADDR_SCR, d, oe);
        chk(d, v);
        conclude();
    end
endmodule
